// >>> hw/cfl_defines.svh
// constants for the card format load and interrogate executor
// assumes inclusion by the package, the design module and the bench
//
// Functional notes
// - format band digit keeps two low bits; 4 and 8 weights dropped.
// - execute start loads operand address into word counter; decrement after each read.
// - word counter decrements modulo installed storage size, wrapping from zero.
// - buffer unit pacing drives transfer; its cycle always completes, even on error.
// - bad address inhibits all transfer, band left zero, alarm after cycle.
// - digit check runs on right shift, only after buffer unit has control.
// - digit error stops transfer at once; rest zero; alarm after cycle ends.
// - output load op 63 fills positions 1..316; last word gives eight digits.
// - output load f digit pairs select bands one to five.
// - odd sign digit applies index register modification to address.
// - normal output load: clear D, counter plus one, word counter base minus 29.
// - input load address or unit alarm: clear D, counter plus one, word counter holds base.
// - input ready op branches when ready; absent unit raises alarm.
// - output ready op 65 branches when ready; absent unit raises alarm.
// - input load op 62: f selects band; even releases, odd imposes lockout.
// - input load fills positions 1..315; last word gives seven digits.
`ifndef CFL_DEFINES_SVH
`define CFL_DEFINES_SVH
`define CFL_OP_IN_LOAD     8'h62
`define CFL_OP_OUT_LOAD    8'h63
`define CFL_OP_IN_READY    8'h64
`define CFL_OP_OUT_READY   8'h65
`define CFL_WORDS          5'd29
`define CFL_DIGITS_WORD    4'd11
`define CFL_LAST_IN        4'd7
`define CFL_LAST_OUT       4'd8
`define CFL_MEM_SIZE       14'h0FA0
`define CFL_ADDR_W         14
`define CFL_ADR_CTRL       12'h000
`define CFL_ADR_INSTR      12'h004
`define CFL_ADR_PC         12'h008
`define CFL_ADR_BREG       12'h00C
`define CFL_ADR_WAC        12'h010
`define CFL_ADR_STAT       12'h014
`define CFL_ADR_MASK       12'h018
`define CFL_ADR_CORE_SIZE  12'h01C
`define CFL_ADR_LOCKOUT    12'h020
`endif

// >>> hw/cfl_pkg.sv
// types for the card format load and interrogate executor
// assumes the defines header sits beside it
`include "cfl_defines.svh"
package cfl_pkg;
   typedef enum logic [1:0] {CFL_ALM_ADDR, CFL_ALM_UNIT, CFL_ALM_DIGIT, CFL_ALM_DONE} cfl_cause_t;
   typedef enum logic [2:0] {
      CFL_IDLE, CFL_DECODE, CFL_FETCH, CFL_SHIFT, CFL_FINISH, CFL_HALT
   } cfl_state_t;
   // request toward core storage
   typedef struct packed {
      logic        rd;
      logic [13:0] addr;
   } cfl_mem_req_t;
   // one digit toward the buffer unit band
   typedef struct packed {
      logic       wr;
      logic [2:0] band;
      logic [8:0] pos;
      logic [1:0] val;
      logic       unit_out;
   } cfl_band_wr_t;
endpackage

// >>> hw/cfl_core.sv
// executor for format load and ready interrogate instructions
// assumes apb master, single-cycle core storage, buffer unit strobes pacing
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "cfl_defines.svh"
module cfl_core (
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // core storage
   output cfl_pkg::cfl_mem_req_t     mem_req,
   input  wire logic [43:0]          mem_rdata,
   // buffer unit pins
   input  wire logic                 buf_tick_pin,
   input  wire logic                 buf_ready_pin,
   input  wire logic                 buf_exist_pin,
   output cfl_pkg::cfl_band_wr_t     band_wr,
   output logic [3:0]                buf_unit,
   output logic                      buf_cycle_end,
   // interrupt and halt
   output logic                      irq,
   output logic                      halted
);
   import cfl_pkg::*;

   // ************************************************
   // pin synchronisers
   // ************************************************
   logic [2:0] pin_s1_reg;
   logic [2:0] pin_s2_reg;
   logic       tick_prev_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_reg    <= 3'h0;
         pin_s2_reg    <= 3'h0;
         tick_prev_reg <= 1'b0;
      end else begin
         pin_s1_reg    <= {buf_tick_pin, buf_ready_pin, buf_exist_pin};
         pin_s2_reg    <= pin_s1_reg;
         tick_prev_reg <= pin_s2_reg[2];
      end
   end
   wire tick  = pin_s2_reg[2] & ~tick_prev_reg;
   wire ready = pin_s2_reg[1];
   wire exist = pin_s2_reg[0];

   // ************************************************
   // registers
   // ************************************************
   logic [43:0] instr_reg;
   logic [13:0] pc_reg;
   logic [13:0] breg_reg;
   logic [13:0] wac_reg;
   logic [13:0] core_size_reg;
   logic [3:0]  stat_reg;
   logic [3:0]  mask_reg;
   logic        lockout_reg;
   logic        start_pulse;
   cfl_state_t  state_reg;

   wire wr_en = psel & penable & pwrite;
   wire hit_ctrl  = paddr == `CFL_ADR_CTRL;
   wire hit_instr = paddr == `CFL_ADR_INSTR;
   wire hit_pc    = paddr == `CFL_ADR_PC;
   wire hit_breg  = paddr == `CFL_ADR_BREG;
   wire hit_wac   = paddr == `CFL_ADR_WAC;
   wire hit_stat  = paddr == `CFL_ADR_STAT;
   wire hit_mask  = paddr == `CFL_ADR_MASK;
   wire hit_size  = paddr == `CFL_ADR_CORE_SIZE;
   wire hit_lock  = paddr == `CFL_ADR_LOCKOUT;
   wire hit_any   = hit_ctrl | hit_instr | hit_pc | hit_breg | hit_wac | hit_stat
                  | hit_mask | hit_size | hit_lock;
   // instruction writes refused while running
   wire busy      = state_reg != CFL_IDLE;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign start_pulse = wr_en & hit_ctrl & pwdata[0] & ~busy;

   // ************************************************
   // instruction field decode
   // ************************************************
   wire [3:0]  sign_dig = instr_reg[43:40];
   wire [3:0]  unit_dig = instr_reg[39:36];
   wire [3:0]  f_dig    = instr_reg[27:24];
   wire [7:0]  op_code  = instr_reg[23:16];
   wire [15:0] aaaa     = instr_reg[15:0];
   wire [13:0] aaaa_bin = 14'd1000 * 14'(aaaa[15:12]) + 14'd100 * 14'(aaaa[11:8])
                        + 14'd10 * 14'(aaaa[7:4]) + 14'(aaaa[3:0]);
   wire [14:0] mod_sum  = {1'b0, aaaa_bin} + {1'b0, breg_reg};
   wire [14:0] mod_wrap = (mod_sum >= {1'b0, core_size_reg}) ?
                          mod_sum - {1'b0, core_size_reg} : mod_sum;
   wire [13:0] eff_addr = sign_dig[0] ? mod_wrap[13:0] : aaaa_bin;
   wire is_in_load   = op_code == `CFL_OP_IN_LOAD;
   wire is_out_load  = op_code == `CFL_OP_OUT_LOAD;
   wire is_in_ready  = op_code == `CFL_OP_IN_READY;
   wire is_out_ready = op_code == `CFL_OP_OUT_READY;
   wire [2:0] band_sel = 3'(f_dig >> 1) + 3'd1;
   wire [3:0] last_cnt = is_out_load ? `CFL_LAST_OUT : `CFL_LAST_IN;
   wire bad_addr = wac_reg >= core_size_reg;
   wire [13:0] wac_dec = (wac_reg == 14'h0) ? core_size_reg - 14'h1 : wac_reg - 14'h1;

   // ************************************************
   // sequencer
   // ************************************************
   logic [4:0]  word_cnt_reg;
   logic [3:0]  dig_cnt_reg;
   logic [8:0]  pos_reg;
   logic [43:0] shift_reg;
   logic        inhibit_reg;
   logic        addr_err_reg;
   logic        dig_err_reg;
   logic        dreg_clear_reg;
   logic        unit_err_ev;
   logic        addr_err_ev;
   logic        dig_err_ev;
   logic        done_ev;
   wire [3:0] cur_dig   = shift_reg[3:0];
   wire       dig_bad   = cur_dig > 4'h9;
   wire       last_word = word_cnt_reg == `CFL_WORDS - 5'd1;
   wire [3:0] word_len  = last_word ? last_cnt : `CFL_DIGITS_WORD;
   wire       word_done = dig_cnt_reg == word_len - 4'd1;
   wire       wr_digit  = (state_reg == CFL_SHIFT) & tick & ~inhibit_reg & ~dig_bad;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg      <= CFL_IDLE;
         wac_reg        <= 14'h0;
         pc_reg         <= 14'h0;
         word_cnt_reg   <= 5'h0;
         dig_cnt_reg    <= 4'h0;
         pos_reg        <= 9'h0;
         shift_reg      <= 44'h0;
         inhibit_reg    <= 1'b0;
         addr_err_reg   <= 1'b0;
         dig_err_reg    <= 1'b0;
         dreg_clear_reg <= 1'b0;
         lockout_reg    <= 1'b0;
      end else begin
         if (wr_en & hit_pc & ~busy)
            pc_reg <= pwdata[13:0];
         if (wr_en & hit_wac & ~busy)
            wac_reg <= pwdata[13:0];
         unique case (state_reg)
            CFL_IDLE: begin
               if (start_pulse) begin
                  state_reg      <= CFL_DECODE;
                  dreg_clear_reg <= 1'b0;
               end
            end
            CFL_DECODE: begin
               wac_reg      <= eff_addr;
               word_cnt_reg <= 5'h0;
               dig_cnt_reg  <= 4'h0;
               pos_reg      <= 9'h1;
               inhibit_reg  <= 1'b0;
               addr_err_reg <= 1'b0;
               dig_err_reg  <= 1'b0;
               if (!exist) begin
                  state_reg <= CFL_FINISH;
               end else if (is_in_ready | is_out_ready) begin
                  state_reg <= CFL_FINISH;
               end else if (is_in_load | is_out_load) begin
                  state_reg <= CFL_FETCH;
                  if (is_in_load)
                     lockout_reg <= f_dig[0];
               end else begin
                  state_reg <= CFL_FINISH;
               end
            end
            CFL_FETCH: begin
               if (tick) begin
                  if (bad_addr & ~inhibit_reg) begin
                     inhibit_reg  <= 1'b1;
                     addr_err_reg <= 1'b1;
                     wac_reg      <= eff_addr;
                  end
                  shift_reg <= (bad_addr | inhibit_reg) ? 44'h0 : mem_rdata;
                  if (!(bad_addr | inhibit_reg))
                     wac_reg <= wac_dec;
                  dig_cnt_reg <= 4'h0;
                  state_reg   <= CFL_SHIFT;
               end
            end
            CFL_SHIFT: begin
               if (tick) begin
                  if (dig_bad & ~inhibit_reg) begin
                     inhibit_reg <= 1'b1;
                     dig_err_reg <= 1'b1;
                  end
                  shift_reg   <= {4'h0, shift_reg[43:4]};
                  pos_reg     <= pos_reg + 9'h1;
                  dig_cnt_reg <= dig_cnt_reg + 4'h1;
                  if (word_done) begin
                     word_cnt_reg <= word_cnt_reg + 5'h1;
                     state_reg    <= last_word ? CFL_FINISH : CFL_FETCH;
                  end
               end
            end
            CFL_FINISH: begin
               pc_reg         <= pc_reg + 14'h1;
               dreg_clear_reg <= 1'b1;
               if ((is_in_ready | is_out_ready) & exist & ready)
                  pc_reg <= eff_addr;
               if (!exist & (is_in_load | is_out_load))
                  wac_reg <= eff_addr;
               state_reg <= (!exist | addr_err_reg | dig_err_reg) ? CFL_HALT : CFL_IDLE;
            end
            CFL_HALT: begin
               if (wr_en & hit_ctrl & pwdata[1])
                  state_reg <= CFL_IDLE;
            end
            default: state_reg <= CFL_IDLE;
         endcase
      end
   end

   // ************************************************
   // events and interrupt status
   // ************************************************
   assign unit_err_ev = (state_reg == CFL_FINISH) & ~exist;
   assign addr_err_ev = (state_reg == CFL_FINISH) & addr_err_reg;
   assign dig_err_ev  = (state_reg == CFL_FINISH) & dig_err_reg;
   assign done_ev     = (state_reg == CFL_FINISH);
   wire [3:0] ev_vec  = {done_ev, dig_err_ev, unit_err_ev, addr_err_ev};
   wire [3:0] clr_vec = (wr_en & hit_stat) ? pwdata[3:0] : 4'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_reg      <= 4'h0;
         mask_reg      <= 4'h0;
         instr_reg     <= 44'h0;
         breg_reg      <= 14'h0;
         core_size_reg <= `CFL_MEM_SIZE;
      end else begin
         stat_reg <= (stat_reg & ~clr_vec) | ev_vec;
         if (wr_en & hit_mask)
            mask_reg <= pwdata[3:0];
         if (wr_en & hit_instr & ~busy)
            instr_reg <= {pwdata[31:0], 12'h0} | 44'(pwdata[11:0]);
         if (wr_en & hit_breg & ~busy)
            breg_reg <= pwdata[13:0];
         if (wr_en & hit_size & ~busy)
            core_size_reg <= pwdata[13:0];
      end
   end
   assign irq    = |(stat_reg & mask_reg);
   assign halted = state_reg == CFL_HALT;

   // ************************************************
   // outputs
   // ************************************************
   wire [31:0] rd_mux =
        hit_ctrl  ? {29'h0, dreg_clear_reg, halted, busy}
      : hit_instr ? instr_reg[43:12]
      : hit_pc    ? {18'h0, pc_reg}
      : hit_breg  ? {18'h0, breg_reg}
      : hit_wac   ? {18'h0, wac_reg}
      : hit_stat  ? {28'h0, stat_reg}
      : hit_mask  ? {28'h0, mask_reg}
      : hit_size  ? {18'h0, core_size_reg}
      : hit_lock  ? {31'h0, lockout_reg}
      : 32'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata        <= 32'h0;
         band_wr       <= '0;
         buf_unit      <= 4'h0;
         buf_cycle_end <= 1'b0;
      end else begin
         if (psel & ~penable & ~pwrite)
            prdata <= rd_mux;
         band_wr.wr       <= (state_reg == CFL_SHIFT) & tick;
         band_wr.band     <= band_sel;
         band_wr.pos      <= pos_reg;
         band_wr.val      <= wr_digit ? cur_dig[1:0] : 2'h0;
         band_wr.unit_out <= is_out_load | is_out_ready;
         buf_unit         <= unit_dig;
         buf_cycle_end    <= (state_reg == CFL_SHIFT) & tick & word_done & last_word;
      end
   end
   assign mem_req.rd   = (state_reg == CFL_FETCH) & tick & ~bad_addr & ~inhibit_reg;
   assign mem_req.addr = wac_reg;
endmodule

// >>> testbench/cfl_core_assertions.sv
// port checker for the format load executor
// assumes bind onto cfl_core, one clock domain
`timescale 1ns/100ps
module cfl_core_chk (
   // clock and reset
   input wire logic                  pclk,
   input wire logic                  presetn,
   // apb
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic                  pslverr,
   // storage and buffer unit
   input wire cfl_pkg::cfl_mem_req_t mem_req,
   input wire cfl_pkg::cfl_band_wr_t band_wr,
   input wire logic                  buf_cycle_end,
   input wire logic                  halted
);
   import cfl_pkg::*;
   logic [13:0] last_addr;
   logic        have_prev;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ***********************
   // read tracking and checks
   // ***********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_addr <= 14'h0000;
         have_prev <= 1'b0;
      end else if (buf_cycle_end) begin
         have_prev <= 1'b0;
      end else if (mem_req.rd) begin
         last_addr <= mem_req.addr;
         have_prev <= 1'b1;
      end
   end
   a_addr_step: assert property (
      mem_req.rd && have_prev && last_addr != 14'h0000 |-> mem_req.addr == last_addr - 14'h0001)
      else $error("word address not stepped down");
   a_addr_wrap: assert property (
      mem_req.rd && have_prev && last_addr == 14'h0000 |-> mem_req.addr != 14'h0000)
      else $error("word address did not wrap");
   a_band_range: assert property (
      band_wr.wr |-> band_wr.band >= 3'h1 && band_wr.band <= 3'h5)
      else $error("band outside one to five");
   a_out_last: assert property (band_wr.wr && band_wr.unit_out |-> band_wr.pos <= 9'h13C)
      else $error("output position past end");
   a_in_last: assert property (band_wr.wr && !band_wr.unit_out |-> band_wr.pos <= 9'h13B)
      else $error("input position past end");
   a_halt_quiet: assert property (halted |-> !band_wr.wr && !mem_req.rd)
      else $error("transfer while halted");
   a_halt_hold: assert property (
      halted && !(psel && penable && pwrite && paddr == 12'h000 && pwdata[1]) |=> halted)
      else $error("halt left without restart");
   a_end_pulse: assert property (buf_cycle_end |=> !buf_cycle_end)
      else $error("cycle end longer than one cycle");
   a_unmapped_err: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
      else $error("unmapped access without error");
endmodule
bind cfl_core cfl_core_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .mem_req(mem_req), .band_wr(band_wr), .buf_cycle_end(buf_cycle_end), .halted(halted));

// >>> testbench/cfl_buf_model.sv
// buffer unit and core storage model
// assumes the bench sets go, unit levels and the bad word
`timescale 1ns/100ps
module cfl_buf_model (
   // control
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  go,
   input wire logic                  ready_lvl,
   input wire logic                  exist_lvl,
   input wire logic [13:0]           bad_addr,
   // storage and pins
   input wire cfl_pkg::cfl_mem_req_t mem_req,
   output logic [43:0]               mem_rdata,
   output logic                      buf_tick_pin,
   output logic                      buf_ready_pin,
   output logic                      buf_exist_pin
);
   import cfl_pkg::*;
   // ***********************
   // storage words and pacing
   // ***********************
   logic [2:0]  cnt;
   logic [43:0] word;
   assign word = (mem_req.addr == bad_addr) ? {11{4'hA}} : {11{4'(mem_req.addr % 14'h000A)}};
   assign mem_rdata = mem_req.rd ? word : ~word;
   assign buf_tick_pin = go & cnt[2];
   assign buf_ready_pin = ready_lvl;
   assign buf_exist_pin = exist_lvl;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 3'h0;
      end else begin
         cnt <= cnt + 3'h1;
      end
   end
endmodule

// >>> testbench/tb_cfl_core.sv
// bench for the format load and interrogate executor
// assumes cfl_core, the buffer model and the checker compiled first
`timescale 1ns/100ps
`include "cfl_defines.svh"
module tb_cfl_core;
   import cfl_pkg::*;
   // *****************
   // signals and parts
   // *****************
   logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic         go = 1'b0, rdy = 1'b0, ext = 1'b1, first = 1'b0, inhib = 1'b0, exp_out, err;
   logic [11:0]  paddr = 12'h000;
   logic [31:0]  pwdata = 32'h0000_0000, prdata, rd;
   logic         pready, pslverr, tick, rdy_pin, ext_pin, cyc_end, irq, halted;
   logic [43:0]  mem_rdata;
   logic [3:0]   bu;
   logic [2:0]   exp_band;
   logic [1:0]   exp_val;
   logic [13:0]  first_a, last_a, bad = 14'h3FFF;
   cfl_mem_req_t mem_req;
   cfl_band_wr_t band_wr;
   int           errors = 0, cmp_count = 0, cyc = 0, nwr = 0;
   cfl_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata), .buf_tick_pin(tick),
      .buf_ready_pin(rdy_pin), .buf_exist_pin(ext_pin), .band_wr(band_wr), .buf_unit(bu),
      .buf_cycle_end(cyc_end), .irq(irq), .halted(halted));
   cfl_buf_model i_buf (.pclk(pclk), .presetn(presetn), .go(go), .ready_lvl(rdy),
      .exist_lvl(ext), .bad_addr(bad), .mem_req(mem_req), .mem_rdata(mem_rdata),
      .buf_tick_pin(tick), .buf_ready_pin(rdy_pin), .buf_exist_pin(ext_pin));
   always #5 pclk = ~pclk;
   assign exp_val = (inhib || last_a == bad) ? 2'h0 : 2'(last_a % 14'h000A);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run(input logic [31:0] w);
      apb(1'b1, `CFL_ADR_INSTR, w);
      nwr = 0;
      first = 1'b1;
      go <= 1'b1;
      apb(1'b1, `CFL_ADR_CTRL, 32'h0000_0001);
      rd = 32'h0000_0001;
      while (rd[0] !== 1'b0 && rd[1] !== 1'b1) apb(1'b0, `CFL_ADR_CTRL, 32'h0000_0000);
      go <= 1'b0;
   endtask
   task automatic recover(input logic h);
      chk(32'(halted), 32'(h));
      apb(1'b1, `CFL_ADR_CTRL, 32'h0000_0002);
      apb(1'b1, `CFL_ADR_STAT, 32'h0000_000F);
      apb(1'b0, `CFL_ADR_CTRL, 32'h0000_0000);
      chk(32'(rd[1]), 32'h0000_0000);
   endtask
   task automatic results();
      if (errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      if (mem_req.rd === 1'b1) begin
         last_a <= mem_req.addr;
         if (first) chk(32'(mem_req.addr), 32'(first_a));
         first <= 1'b0;
      end
      if (band_wr.wr === 1'b1) begin
         nwr++;
         chk(32'({band_wr.band, band_wr.unit_out, bu}), 32'({exp_band, exp_out, 4'h1}));
         chk(32'(band_wr.val), 32'(exp_val));
         chk(32'(band_wr.pos), 32'(nwr));
      end
      if (cyc_end === 1'b1) chk(32'(nwr), exp_out ? 32'h0000_013C : 32'h0000_013B);
      cyc++;
      if (cyc == 100000) begin
         errors++;
         results();
      end
   end
   // *********
   // sequence
   // *********
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CFL_ADR_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h024, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      apb(1'b1, `CFL_ADR_CORE_SIZE, 32'h0000_03E8);
      apb(1'b1, `CFL_ADR_BREG, 32'h0000_0005);
      exp_out = 1'b1;
      for (int f = 0; f < 10; f++) begin
         exp_band = 3'(f / 2 + 1);
         first_a = f[0] ? 14'h027B : 14'h0276;
         apb(1'b1, `CFL_ADR_PC, 32'h0000_0064);
         run({3'h0, f[0], 12'h100, 4'(f), 12'h630});
         chk(32'(rd[2]), 32'h0000_0001);
         chk(32'(nwr), 32'h0000_013C);
         apb(1'b0, `CFL_ADR_WAC, 32'h0000_0000);
         chk(rd, 32'(first_a - 14'h001D));
         apb(1'b0, `CFL_ADR_PC, 32'h0000_0000);
         chk(rd, 32'h0000_0065);
         @(negedge pclk);
         chk(32'(irq), 32'(f != 0));
         apb(1'b1, `CFL_ADR_MASK, 32'h0000_0008);
         @(negedge pclk);
         chk(32'(irq), 32'h0000_0001);
         apb(1'b1, `CFL_ADR_STAT, 32'h0000_000F);
         @(negedge pclk);
         chk(32'(irq), 32'h0000_0000);
      end
      exp_out = 1'b0;
      exp_band = 3'h2;
      first_a = 14'h026C;
      for (int f = 3; f > 1; f--) begin
         run({16'h0100, 4'(f), 12'h620});
         chk(32'(nwr), 32'h0000_013B);
         apb(1'b0, `CFL_ADR_LOCKOUT, 32'h0000_0000);
         chk(rd, 32'(f % 2));
         apb(1'b1, `CFL_ADR_STAT, 32'h0000_000F);
      end
      apb(1'b1, `CFL_ADR_BREG, 32'h0000_0190);
      first_a = 14'h0014;
      run(32'h1100_2620);
      apb(1'b0, `CFL_ADR_WAC, 32'h0000_0000);
      chk(rd, 32'h0000_03DF);
      apb(1'b1, `CFL_ADR_STAT, 32'h0000_000F);
      inhib = 1'b1;
      apb(1'b1, `CFL_ADR_CORE_SIZE, 32'h0000_0258);
      apb(1'b1, `CFL_ADR_PC, 32'h0000_0064);
      run(32'h0100_2620);
      apb(1'b0, `CFL_ADR_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0009);
      apb(1'b0, `CFL_ADR_WAC, 32'h0000_0000);
      chk(rd, 32'h0000_026C);
      apb(1'b0, `CFL_ADR_PC, 32'h0000_0000);
      chk(rd, 32'h0000_0065);
      recover(1'b1);
      inhib = 1'b0;
      apb(1'b1, `CFL_ADR_CORE_SIZE, 32'h0000_03E8);
      exp_out = 1'b1;
      bad = 14'h0271;
      first_a = 14'h0276;
      run(32'h0100_2630);
      apb(1'b0, `CFL_ADR_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_000C);
      chk(32'(nwr >= 55), 32'h0000_0001);
      recover(1'b1);
      bad = 14'h3FFF;
      for (int k = 0; k < 6; k++) begin
         rdy <= (k % 3 == 0);
         ext <= (k % 3 != 2);
         apb(1'b1, `CFL_ADR_PC, 32'h0000_0064);
         run({20'h01000, k < 3 ? 8'h64 : 8'h65, 4'h0});
         apb(1'b0, `CFL_ADR_PC, 32'h0000_0000);
         chk(rd, k % 3 != 0 ? 32'h0000_0065 : k < 3 ? 32'h0000_0280 : 32'h0000_028A);
         apb(1'b0, `CFL_ADR_STAT, 32'h0000_0000);
         chk(32'(rd[1]), 32'(k % 3 == 2));
         recover(k % 3 == 2);
      end
      results();
   end
endmodule
